// File: inc/srap_pkg.sv
package srap_pkg;
	localparam int WORD_W = 16;
	localparam int PAGE_W = 4;
	localparam int IDX_W = 6;
	localparam int BIT_W = 4;
	localparam int WORDS_W = 6;
	localparam int CMD_RW_BIT = 15;
	localparam int CMD_PAGE_MSB = 14;
	localparam int CMD_PAGE_LSB = 11;
	localparam int CMD_IDX_MSB = 10;
	localparam int CMD_IDX_LSB = 5;
	localparam logic [CMD_IDX_LSB-1:0] CMD_RSVD = 5'h00;
	localparam int NUM_PAGES = 3;
	localparam int PAGE_WORDS = 32;
	localparam int REG_CNT = NUM_PAGES * PAGE_WORDS;
	localparam int REG_IDX_W = $clog2(REG_CNT);
	localparam logic [WORD_W-1:0] PAST_END_WORD = 16'hffff;
	localparam logic [WORD_W-1:0] REG_RST = 16'h0000;
	localparam logic [IDX_W-1:0] IDX_MAX = 6'h3f;
	localparam logic [BIT_W-1:0] BIT_LAST = 4'hf;
	localparam logic [BIT_W-1:0] BIT_ADDR_DONE = 4'ha;
	localparam int MCLK_NS = 5;
	localparam int SCLK_HALF_NS = 30;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + MCLK_NS - 1) / MCLK_NS;

	typedef enum logic [2:0] {
		H_IDLE,
		H_LEAD,
		H_SHIFT,
		H_TAIL,
		H_GAP
	} srap_hstate_t;

	function automatic logic addrOk(
		input logic [PAGE_W-1:0] page,
		input logic [IDX_W-1:0] idx
	);
		return (int'(page) < NUM_PAGES) && (int'(idx) < PAGE_WORDS);
	endfunction

	function automatic logic [REG_IDX_W-1:0] flatIdx(
		input logic [PAGE_W-1:0] page,
		input logic [IDX_W-1:0] idx
	);
		return REG_IDX_W'(int'(page) * PAGE_WORDS + int'(idx));
	endfunction
endpackage

// File: inc/srap_link_if.sv
`timescale 1ns/1ps
interface srap_link_if;
	logic serialClk;
	logic slaveSelN;
	logic serialDataInPin;
	logic serialDataOutPin;

	modport dev(
		input serialClk,
		input slaveSelN,
		input serialDataInPin,
		output serialDataOutPin
	);

	modport host(
		output serialClk,
		output slaveSelN,
		output serialDataInPin,
		input serialDataOutPin
	);
endinterface

// File: core/srap_sync.sv
`timescale 1ns/1ps
module srap_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// Only the second stage is visible, so nothing samples a metastable bit.
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;
endmodule

// File: core/srap_device.sv
`timescale 1ns/1ps
module srap_device
	import srap_pkg::*;
(
	srap_link_if.dev link,
	input wire logic mclk,
	input wire logic reset,
	input wire logic coreLoad,
	input wire logic [PAGE_W-1:0] coreLoadPage,
	input wire logic [IDX_W-1:0] coreLoadIdx,
	input wire logic [WORD_W-1:0] coreLoadData,
	input wire logic [PAGE_W-1:0] coreRdPage,
	input wire logic [IDX_W-1:0] coreRdIdx,
	output logic [WORD_W-1:0] coreRdData,
	output logic regWrStb,
	output logic [PAGE_W-1:0] regWrPage,
	output logic [IDX_W-1:0] regWrIdx,
	output logic [WORD_W-1:0] regWrData
);
	logic [BIT_W-1:0] bitCnt_q;
	logic inCmd_q;
	logic [WORD_W-2:0] shiftIn_q;
	logic readCmd_q;
	logic [PAGE_W-1:0] page_q;
	logic [IDX_W-1:0] ptr_q;
	logic [WORD_W-1:0] word;
	logic wordDone;
	logic [IDX_W-1:0] ptrNext;
	logic reqTgl_q;
	logic [PAGE_W-1:0] reqPage_q;
	logic [IDX_W-1:0] reqIdx_q;
	logic wrTgl_q;
	logic [PAGE_W-1:0] wrPage_q;
	logic [IDX_W-1:0] wrIdx_q;
	logic [WORD_W-1:0] wrData_q;
	logic [WORD_W-1:0] shiftOut_q;
	logic ackSync;
	logic [1:0] tglSync;
	logic reqSeen_q;
	logic wrSeen_q;
	logic reqEdge;
	logic wrEdge;
	logic ackTgl_q;
	logic [WORD_W-1:0] rdWord_q;
	logic [WORD_W-1:0] regs_q [REG_CNT];
	logic [WORD_W-1:0] coreRdData_q;
	logic regWrStb_q;
	logic [PAGE_W-1:0] regWrPage_q;
	logic [IDX_W-1:0] regWrIdx_q;
	logic [WORD_W-1:0] regWrData_q;

	// The word as it stands once the current bit is sampled.
	assign word = {shiftIn_q, link.serialDataInPin};
	assign wordDone = (bitCnt_q == BIT_LAST);
	// Saturating keeps the pointer beyond the page once it gets there.
	assign ptrNext = (ptr_q == IDX_MAX) ? ptr_q : ptr_q + 1'b1;

	// Sampling happens on the falling edge, half a period after launch.
	// Select high clears the framing, so only a fresh fall opens a command.
	always_ff @(negedge link.serialClk or posedge link.slaveSelN) begin
		if (link.slaveSelN) begin
			bitCnt_q <= '0;
			inCmd_q <= 1'b1;
			shiftIn_q <= '0;
			readCmd_q <= 1'b0;
			page_q <= '0;
			ptr_q <= '0;
		end else begin
			bitCnt_q <= bitCnt_q + 1'b1;
			shiftIn_q <= word[WORD_W-2:0];
			if (wordDone && inCmd_q) begin
				// Later words in this frame are all data.
				inCmd_q <= 1'b0;
				readCmd_q <= word[CMD_RW_BIT];
				page_q <= word[CMD_PAGE_MSB:CMD_PAGE_LSB];
				// The low five bits are not looked at.
				ptr_q <= word[CMD_IDX_MSB:CMD_IDX_LSB];
			end else if (wordDone) begin
				ptr_q <= ptrNext;
			end
		end
	end

	// A read word is fetched well ahead of its first launch edge: once the
	// address bits are in, and at bit ten of each data word for the next.
	// A fetch at the word end would leave half a bit for the round trip.
	always_ff @(negedge link.serialClk or posedge reset) begin
		if (reset) begin
			reqTgl_q <= 1'b0;
			reqPage_q <= '0;
			reqIdx_q <= '0;
		end else if (!link.slaveSelN && bitCnt_q == BIT_ADDR_DONE) begin
			reqTgl_q <= ~reqTgl_q;
			if (inCmd_q) begin
				reqPage_q <= word[CMD_PAGE_MSB-CMD_IDX_LSB:
					CMD_PAGE_LSB-CMD_IDX_LSB];
				reqIdx_q <= word[CMD_IDX_MSB-CMD_IDX_LSB:0];
			end else begin
				reqIdx_q <= ptrNext;
			end
		end
	end

	// Only whole words reach the register file; a cut word never toggles.
	always_ff @(negedge link.serialClk or posedge reset) begin
		if (reset) begin
			wrTgl_q <= 1'b0;
			wrPage_q <= '0;
			wrIdx_q <= '0;
			wrData_q <= '0;
		end else if (!link.slaveSelN && !inCmd_q && wordDone &&
			!readCmd_q && addrOk(page_q, ptr_q)) begin
			wrTgl_q <= ~wrTgl_q;
			wrPage_q <= page_q;
			wrIdx_q <= ptr_q;
			wrData_q <= word;
		end
	end

	srap_sync #(
		.W(1)
	) uAckSync (
		.clk(link.serialClk),
		.reset(1'b0),
		.d(ackTgl_q),
		.q(ackSync)
	);

	// Launch on the rising edge, the first edge of every bit. If a fetch
	// were ever late the word goes out as all ones rather than stale data.
	always_ff @(posedge link.serialClk or posedge link.slaveSelN) begin
		if (link.slaveSelN) begin
			shiftOut_q <= '0;
		end else if (bitCnt_q == '0 && !inCmd_q) begin
			shiftOut_q <= (ackSync == reqTgl_q) ? rdWord_q : PAST_END_WORD;
		end else begin
			shiftOut_q <= {shiftOut_q[WORD_W-2:0], 1'b0};
		end
	end

	// The device only follows the master's clock and select.
	assign link.serialDataOutPin = shiftOut_q[WORD_W-1];

	srap_sync #(
		.W(2)
	) uTglSync (
		.clk(mclk),
		.reset(reset),
		.d({reqTgl_q, wrTgl_q}),
		.q(tglSync)
	);

	assign reqEdge = tglSync[1] ^ reqSeen_q;
	assign wrEdge = tglSync[0] ^ wrSeen_q;

	always_ff @(posedge mclk) begin
		if (reset) begin
			reqSeen_q <= 1'b0;
			wrSeen_q <= 1'b0;
		end else begin
			reqSeen_q <= tglSync[1];
			wrSeen_q <= tglSync[0];
		end
	end

	// The word is held until the next request, long after the acknowledge
	// has crossed back, so the link side reads it stable.
	always_ff @(posedge mclk) begin
		if (reset) begin
			ackTgl_q <= 1'b0;
			rdWord_q <= PAST_END_WORD;
		end else if (reqEdge) begin
			ackTgl_q <= tglSync[1];
			if (addrOk(reqPage_q, reqIdx_q)) begin
				rdWord_q <= regs_q[flatIdx(reqPage_q, reqIdx_q)];
			end else begin
				rdWord_q <= PAST_END_WORD;
			end
		end
	end

	// On a clash at one location the link write lands last and wins.
	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int i = 0; i < REG_CNT; i++) begin
				regs_q[i] <= REG_RST;
			end
		end else begin
			if (coreLoad && addrOk(coreLoadPage, coreLoadIdx)) begin
				regs_q[flatIdx(coreLoadPage, coreLoadIdx)] <= coreLoadData;
			end
			if (wrEdge) begin
				regs_q[flatIdx(wrPage_q, wrIdx_q)] <= wrData_q;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			coreRdData_q <= REG_RST;
		end else if (addrOk(coreRdPage, coreRdIdx)) begin
			coreRdData_q <= regs_q[flatIdx(coreRdPage, coreRdIdx)];
		end else begin
			coreRdData_q <= PAST_END_WORD;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			regWrStb_q <= 1'b0;
			regWrPage_q <= '0;
			regWrIdx_q <= '0;
			regWrData_q <= REG_RST;
		end else begin
			regWrStb_q <= wrEdge;
			if (wrEdge) begin
				regWrPage_q <= wrPage_q;
				regWrIdx_q <= wrIdx_q;
				regWrData_q <= wrData_q;
			end
		end
	end

	assign coreRdData = coreRdData_q;
	assign regWrStb = regWrStb_q;
	assign regWrPage = regWrPage_q;
	assign regWrIdx = regWrIdx_q;
	assign regWrData = regWrData_q;
endmodule

// File: core/srap_host.sv
`timescale 1ns/1ps
module srap_host
	import srap_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC
) (
	srap_link_if.host link,
	input wire logic mclk,
	input wire logic reset,
	input wire logic cmdValid,
	output logic cmdReady,
	input wire logic cmdRead,
	input wire logic [PAGE_W-1:0] cmdPage,
	input wire logic [IDX_W-1:0] cmdIdx,
	input wire logic [WORDS_W-1:0] cmdWords,
	input wire logic [WORD_W-1:0] wrData,
	output logic wrTake,
	output logic rdValid,
	output logic [WORD_W-1:0] rdData
);
	localparam int DIV_W = $clog2(HALF_CYC + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYC - 1);

	srap_hstate_t state_q;
	logic [DIV_W-1:0] divCnt_q;
	logic sclk_q;
	logic ssN_q;
	logic mosi_q;
	logic [WORD_W-1:0] txShift_q;
	logic [WORD_W-1:0] rxShift_q;
	logic [BIT_W-1:0] bitCnt_q;
	logic [WORDS_W-1:0] wordsLeft_q;
	logic dataPhase_q;
	logic readMode_q;
	logic cmdReady_q;
	logic wrTake_q;
	logic rdValid_q;
	logic [WORD_W-1:0] rdData_q;
	logic misoSync;
	logic start;
	logic tick;
	logic doRise;
	logic doFall;
	logic wordEnd;
	logic [WORD_W-1:0] rxWord;

	srap_sync #(
		.W(1)
	) uMisoSync (
		.clk(mclk),
		.reset(reset),
		.d(link.serialDataOutPin),
		.q(misoSync)
	);

	assign start = (state_q == H_IDLE) && cmdValid && cmdReady_q;
	assign tick = (state_q != H_IDLE) && (divCnt_q == DIV_LAST);
	assign doRise = tick && ((state_q == H_LEAD) ||
		(state_q == H_SHIFT && !sclk_q));
	assign doFall = tick && (state_q == H_SHIFT) && sclk_q;
	assign wordEnd = doFall && (bitCnt_q == BIT_LAST);
	assign rxWord = {rxShift_q[WORD_W-2:0], misoSync};

	always_ff @(posedge mclk) begin
		if (reset || state_q == H_IDLE || tick) begin
			divCnt_q <= '0;
		end else begin
			divCnt_q <= divCnt_q + 1'b1;
		end
	end

	// Every frame opens with a fresh select fall and closes with a rise.
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_q <= H_IDLE;
		end else begin
			case (state_q)
				H_IDLE: if (start) state_q <= H_LEAD;
				H_LEAD: if (tick) state_q <= H_SHIFT;
				H_SHIFT: if (wordEnd && wordsLeft_q == '0) state_q <= H_TAIL;
				H_TAIL: if (tick) state_q <= H_GAP;
				H_GAP: if (tick) state_q <= H_IDLE;
				default: state_q <= H_IDLE;
			endcase
		end
	end

	// The clock rests low; data changes with each rising edge.
	always_ff @(posedge mclk) begin
		if (reset) begin
			sclk_q <= 1'b0;
			ssN_q <= 1'b1;
			mosi_q <= 1'b0;
		end else begin
			if (start) ssN_q <= 1'b0;
			else if (state_q == H_TAIL && tick) ssN_q <= 1'b1;
			if (doRise) begin
				sclk_q <= 1'b1;
				mosi_q <= txShift_q[WORD_W-1];
			end else if (doFall) begin
				sclk_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			txShift_q <= '0;
			wrTake_q <= 1'b0;
		end else begin
			wrTake_q <= wordEnd && !readMode_q && wordsLeft_q != '0;
			if (start) begin
				txShift_q <= {cmdRead, cmdPage, cmdIdx,
					CMD_RSVD};
			end else if (doRise) begin
				txShift_q <= {txShift_q[WORD_W-2:0], 1'b0};
			end else if (wordEnd) begin
				txShift_q <= readMode_q ? '0 : wrData;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			rxShift_q <= '0;
			rdValid_q <= 1'b0;
			rdData_q <= '0;
		end else begin
			rdValid_q <= wordEnd && readMode_q && dataPhase_q;
			if (doFall) rxShift_q <= rxWord;
			if (wordEnd && readMode_q && dataPhase_q) rdData_q <= rxWord;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			bitCnt_q <= '0;
			wordsLeft_q <= '0;
			dataPhase_q <= 1'b0;
			readMode_q <= 1'b0;
			cmdReady_q <= 1'b0;
		end else begin
			cmdReady_q <= (state_q == H_IDLE && !start) ||
				(state_q == H_GAP && tick);
			if (start) begin
				bitCnt_q <= '0;
				wordsLeft_q <= cmdWords;
				dataPhase_q <= 1'b0;
				readMode_q <= cmdRead;
			end else if (doFall) begin
				bitCnt_q <= bitCnt_q + 1'b1;
				if (wordEnd) begin
					dataPhase_q <= 1'b1;
					if (wordsLeft_q != '0) wordsLeft_q <= wordsLeft_q - 1'b1;
				end
			end
		end
	end

	assign link.serialClk = sclk_q;
	assign link.slaveSelN = ssN_q;
	assign link.serialDataInPin = mosi_q;
	assign cmdReady = cmdReady_q;
	assign wrTake = wrTake_q;
	assign rdValid = rdValid_q;
	assign rdData = rdData_q;
endmodule

// File: testbench/srap_link_sva.sv
`timescale 1ns/1ps
module srap_link_sva (
	input wire logic mclk,
	input wire logic reset,
	input wire logic serialClk,
	input wire logic slaveSelN,
	input wire logic serialDataInPin,
	input wire logic serialDataOutPin
);
	logic [11:0] riseCnt_q;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	// Counted per frame, so a short frame cannot hide in a running total.
	always_ff @(posedge mclk) begin
		if (reset || slaveSelN) begin
			riseCnt_q <= 12'h000;
		end else if ($rose(serialClk)) begin
			riseCnt_q <= riseCnt_q + 12'h001;
		end
	end

	idle_clk_a: assert property (slaveSelN |-> !serialClk)
		else $error("Serial clock high outside a frame.");
	dout_idle_a: assert property (
		slaveSelN && $past(slaveSelN) |-> !serialDataOutPin)
		else $error("Data out active outside a frame.");
	clk_half_a: assert property ($rose(serialClk) |=> serialClk [*2])
		else $error("Serial clock high phase too short.");
	din_launch_a: assert property (
		$changed(serialDataInPin) && serialClk |-> $rose(serialClk))
		else $error("Data in moved away from a rising edge.");
	dout_launch_a: assert property (
		$changed(serialDataOutPin) && serialClk |-> $rose(serialClk))
		else $error("Data out moved away from a rising edge.");
	frame_words_a: assert property (
		$rose(slaveSelN) |-> riseCnt_q[3:0] == 4'h0 && riseCnt_q >= 12'h010)
		else $error("Frame is not whole 16-bit words.");
	cmd_rsvd_a: assert property ($fell(serialClk) &&
		riseCnt_q >= 12'h00c && riseCnt_q <= 12'h010 |-> !serialDataInPin)
		else $error("Reserved command bit not zero.");
	cmd_dout_a: assert property ($fell(serialClk) && !slaveSelN &&
		riseCnt_q <= 12'h010 |-> !serialDataOutPin)
		else $error("Data out not zero during command word.");
endmodule

// File: testbench/tb_spi_register_access_port.sv
`timescale 1ns/1ps
module tb_spi_register_access_port;
	import srap_pkg::*;
	logic mclk, reset, cmdValid, cmdReady, cmdRead, wrTake, rdValid;
	logic [3:0] cmdPage, coreLoadPage, coreRdPage, regWrPage;
	logic [5:0] cmdIdx, cmdWords, coreLoadIdx, coreRdIdx, regWrIdx;
	logic [15:0] wrData, rdData, coreLoadData, coreRdData, regWrData;
	logic coreLoad, regWrStb;
	logic [15:0] wd [8];
	logic [15:0] rq [$];
	logic [25:0] sq [$];
	int wk, mismatches, nChecks;

	assign wrData = wd[wk[2:0]];

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	srap_link_if link();
	srap_host #(.HALF_CYC(3)) srap_host_inst(.link(link), .mclk(mclk),
		.reset(reset), .cmdValid(cmdValid), .cmdReady(cmdReady),
		.cmdRead(cmdRead), .cmdPage(cmdPage), .cmdIdx(cmdIdx),
		.cmdWords(cmdWords), .wrData(wrData), .wrTake(wrTake),
		.rdValid(rdValid), .rdData(rdData));
	srap_device srap_device_inst(.link(link), .mclk(mclk), .reset(reset),
		.coreLoad(coreLoad), .coreLoadPage(coreLoadPage),
		.coreLoadIdx(coreLoadIdx), .coreLoadData(coreLoadData),
		.coreRdPage(coreRdPage), .coreRdIdx(coreRdIdx),
		.coreRdData(coreRdData), .regWrStb(regWrStb),
		.regWrPage(regWrPage), .regWrIdx(regWrIdx), .regWrData(regWrData));
	srap_link_sva srap_link_sva_inst(.mclk(mclk), .reset(reset),
		.serialClk(link.serialClk), .slaveSelN(link.slaveSelN),
		.serialDataInPin(link.serialDataInPin),
		.serialDataOutPin(link.serialDataOutPin));

	always @(posedge mclk) begin
		if (rdValid === 1'b1) rq.push_back(rdData);
		if (regWrStb === 1'b1) sq.push_back({regWrPage, regWrIdx, regWrData});
		if (wrTake === 1'b1) begin
			#1;
			wk++;
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", nChecks, mismatches);
		if (mismatches == 0 && nChecks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic load(input logic [3:0] pg, input logic [5:0] ix,
		input logic [15:0] d);
		coreLoad = 1'b1;
		coreLoadPage = pg;
		coreLoadIdx = ix;
		coreLoadData = d;
		@(posedge mclk);
		#1;
		coreLoad = 1'b0;
		// One idle edge, so a second call never lifts the strobe at once.
		@(posedge mclk);
		#1;
	endtask

	task automatic peek(input logic [3:0] pg, input logic [5:0] ix,
		input logic [15:0] exp);
		coreRdPage = pg;
		coreRdIdx = ix;
		repeat (2) @(posedge mclk);
		#1;
		chk("coreRdData", coreRdData, exp);
	endtask

	task automatic xfer(input logic rd, input logic [3:0] pg,
		input logic [5:0] ix, input logic [5:0] n);
		rq.delete();
		sq.delete();
		wk = 0;
		cmdRead = rd;
		cmdPage = pg;
		cmdIdx = ix;
		cmdWords = n;
		cmdValid = 1'b1;
		@(posedge mclk);
		#1;
		cmdValid = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		for (int t = 0; t < 9000 && cmdReady !== 1'b1; t++) begin
			@(posedge mclk);
			#1;
		end
		chk("cmdReady", cmdReady, 32'h1);
	endtask

	initial begin
		#300000;
		mismatches++;
		tally_and_finish();
	end

	initial begin
		mismatches = 0;
		nChecks = 0;
		wk = 0;
		// A true rising edge, so the link-side toggles surely clear.
		reset = 1'b0;
		#1;
		reset = 1'b1;
		cmdValid = 1'b0;
		cmdRead = 1'b0;
		cmdPage = 4'h0;
		cmdIdx = 6'h00;
		cmdWords = 6'h00;
		coreLoad = 1'b0;
		coreLoadPage = 4'h0;
		coreLoadIdx = 6'h00;
		coreLoadData = 16'h0000;
		coreRdPage = 4'h0;
		coreRdIdx = 6'h00;
		foreach (wd[i]) wd[i] = 16'h0000;
		repeat (4) @(posedge mclk);
		#1;
		reset = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
		peek(4'h1, 6'h00, REG_RST);
		load(4'h0, 6'h00, 16'h1234);
		load(4'h0, 6'h01, 16'hbeef);
		load(4'h0, 6'h1e, 16'h8001);
		load(4'h0, 6'h1f, 16'h7ffe);
		xfer(1'b1, 4'h0, 6'h00, 6'h03);
		chk("rdWord0", rq[0], 16'h1234);
		chk("rdWord1", rq[1], 16'hbeef);
		chk("rdWord2", rq[2], REG_RST);
		xfer(1'b1, 4'h0, 6'h1e, 6'h04);
		chk("rdCount", rq.size(), 32'h4);
		chk("rdLast", rq[1], 16'h7ffe);
		chk("pastEnd2", rq[2], PAST_END_WORD);
		chk("pastEnd3", rq[3], PAST_END_WORD);
		wd[0] = 16'h1111;
		wd[1] = 16'h2222;
		wd[2] = 16'h3333;
		xfer(1'b0, 4'h1, 6'h00, 6'h03);
		chk("strobes", sq.size(), 32'h3);
		for (int i = 0; i < 3; i++) begin
			chk("wrTarget", sq[i], {4'h1, 6'(i), wd[i]});
		end
		peek(4'h1, 6'h02, 16'h3333);
		xfer(1'b0, 4'h3, 6'h00, 6'h01);
		chk("rsvdPageWr", sq.size(), 32'h0);
		xfer(1'b0, 4'h2, 6'h1f, 6'h02);
		chk("pageEndWr", sq.size(), 32'h1);
		peek(4'h2, 6'h1f, 16'h1111);
		xfer(1'b1, 4'h3, 6'h00, 6'h01);
		chk("rsvdPageRd", rq[0], PAST_END_WORD);
		for (int p = 0; p < NUM_PAGES; p++) begin
			wd[0] = 16'ha5a0 + 16'(p);
			xfer(1'b0, 4'(p), 6'h05, 6'h01);
			chk("pageWr", sq[0], {4'(p), 6'h05, wd[0]});
			xfer(1'b1, 4'(p), 6'h05, 6'h01);
			chk("readNoWr", sq.size(), 32'h0);
			chk("pageRd", rq[0], wd[0]);
		end
		tally_and_finish();
	end
endmodule
